/* common/mod_pll_pkg.sv */
// What this block does
// - ramp code selects Tari or 100/200/400us
// - one bit picks linear or sinusoidal transient
// - coarse level 0, -8, -12 dB; 11 reserved
// - first-Tari high period, range 5f to 9d
// - first-Tari step 50/100/200 ns by Tari
// - reference selector gives 125/100/50/25 kHz
// - main divider N = 32*B + 33*A
// - main B split over main regs one, two
// - aux divider N = 32*B + 33*A
// - aux B and A high bits in aux regs
package mod_pll_pkg;

  // -------------------------------------------------------------------------
  // register word indices; the byte address is four times the index
  // -------------------------------------------------------------------------
  localparam logic [7:0] idx_ramp_level  = 8'h15;
  localparam logic [7:0] idx_first_tari  = 8'h16;
  localparam logic [7:0] idx_main_one    = 8'h17;
  localparam logic [7:0] idx_main_two    = 8'h18;
  localparam logic [7:0] idx_main_three  = 8'h19;
  localparam logic [7:0] idx_aux_one     = 8'h1a;
  localparam logic [7:0] idx_aux_two     = 8'h1b;
  localparam logic [7:0] idx_aux_three   = 8'h1c;
  localparam logic [7:0] idx_status      = 8'h1d;
  localparam int         reg_count       = 9;
  localparam int         addr_lsb        = 2;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] rst_ramp_level  = 8'h00;
  localparam logic [7:0] rst_first_tari  = 8'h7e;
  localparam logic [7:0] rst_main_one    = 8'h64;
  localparam logic [7:0] rst_main_two    = 8'h68;
  localparam logic [7:0] rst_main_three  = 8'hfc;
  localparam logic [7:0] rst_aux_one     = 8'h04;
  localparam logic [7:0] rst_aux_two     = 8'h61;
  localparam logic [7:0] rst_aux_three   = 8'h18;

  // -------------------------------------------------------------------------
  // writable bit masks; reserved bits always read zero
  // -------------------------------------------------------------------------
  localparam logic [7:0] mask_full       = 8'hff;
  localparam logic [7:0] mask_ref_b      = 8'h7f;
  localparam logic [7:0] mask_b_high     = 8'h0f;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int ramp_hi      = 7;
  localparam int ramp_lo      = 6;
  localparam int shape_bit    = 5;
  localparam int coarse_hi    = 4;
  localparam int coarse_lo    = 3;
  localparam int fine_hi      = 2;
  localparam int ref_hi       = 6;
  localparam int ref_lo       = 4;
  localparam int b_high_hi    = 3;
  localparam int b_low_lo     = 2;
  localparam int a_high_hi    = 1;
  localparam int div_w        = 10;
  localparam int ratio_w      = 16;

  // -------------------------------------------------------------------------
  // field codes
  // -------------------------------------------------------------------------
  localparam logic [1:0] ramp_tari       = 2'h0;
  localparam logic [1:0] ramp_100us      = 2'h1;
  localparam logic [1:0] ramp_200us      = 2'h2;
  localparam logic [1:0] ramp_400us      = 2'h3;
  localparam logic [1:0] coarse_rsvd     = 2'h3;
  localparam logic [2:0] ref_125k        = 3'h4;
  localparam logic [2:0] ref_100k        = 3'h5;
  localparam logic [2:0] ref_50k         = 3'h6;
  localparam logic [2:0] ref_25k         = 3'h7;
  localparam logic [7:0] tari_len_min    = 8'h5f;
  localparam logic [7:0] tari_len_max    = 8'h9d;
  localparam logic [5:0] mul_b           = 6'h20;
  localparam logic [5:0] mul_a           = 6'h21;

  // -------------------------------------------------------------------------
  // timing in microseconds and nanoseconds at a 4 ns clock
  // -------------------------------------------------------------------------
  localparam int clk_period_ns   = 4;
  localparam int ramp_100_us     = 100;
  localparam int ramp_200_us     = 200;
  localparam int ramp_400_us     = 400;
  localparam int ramp_100_cyc    = ramp_100_us * 1000 / clk_period_ns;
  localparam int ramp_200_cyc    = ramp_200_us * 1000 / clk_period_ns;
  localparam int ramp_400_cyc    = ramp_400_us * 1000 / clk_period_ns;
  localparam int step_short_ns   = 50;
  localparam int step_mid_ns     = 100;
  localparam int step_long_ns    = 200;
  localparam int step_short_cyc  = (step_short_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int step_mid_cyc    = (step_mid_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int step_long_cyc   = (step_long_ns + clk_period_ns - 1) / clk_period_ns;

  // reference comparison frequency in kHz
  localparam logic [7:0] freq_125_khz    = 8'h7d;
  localparam logic [7:0] freq_100_khz    = 8'h64;
  localparam logic [7:0] freq_50_khz     = 8'h32;
  localparam logic [7:0] freq_25_khz     = 8'h19;

  typedef enum logic [1:0] {tari_short, tari_mid, tari_long} tari_sel_t;

endpackage : mod_pll_pkg

/* core/synth_ratio.sv */
// -------------------------------------------------------------------------
// divider ratio, registered
// -------------------------------------------------------------------------
module synth_ratio #(
  parameter int div_w = 10
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [div_w-1:0]    div_b,
  input  wire logic [div_w-1:0]    div_a,
  output logic      [15:0]         ratio
);

  wire [15:0] prod_b = 16'(div_b) * 16'(mod_pll_pkg::mul_b);
  wire [15:0] prod_a = 16'(div_a) * 16'(mod_pll_pkg::mul_a);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ratio <= 16'h0000;
    else
      ratio <= prod_b + prod_a;
  end

endmodule : synth_ratio

/* core/first_tari_step.sv */
// -------------------------------------------------------------------------
// clock cycles in the first-Tari high period
// -------------------------------------------------------------------------
module first_tari_step (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [7:0]                    len_code,
  input  wire mod_pll_pkg::tari_sel_t        tari_sel,
  output logic      [15:0]                   high_cycles
);

  logic [5:0] step_cyc;

  always_comb
  begin
    unique case (tari_sel)
      mod_pll_pkg::tari_short: step_cyc = 6'(mod_pll_pkg::step_short_cyc);
      mod_pll_pkg::tari_mid:   step_cyc = 6'(mod_pll_pkg::step_mid_cyc);
      mod_pll_pkg::tari_long:  step_cyc = 6'(mod_pll_pkg::step_long_cyc);
      default:                 step_cyc = 6'(mod_pll_pkg::step_mid_cyc);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_cycles <= 16'h0000;
    else
      high_cycles <= 16'(len_code) * 16'(step_cyc);
  end

endmodule : first_tari_step

/* core/modulator_pll_config_regs.sv */
// The APB register port was decided locally.
module modulator_pll_config_regs (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  input  wire mod_pll_pkg::tari_sel_t tari_sel,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic      [1:0]             ramp_code,
  output logic      [17:0]            ramp_cycles,
  output logic                        ramp_follows_tari,
  output logic                        sine_transient,
  output logic      [1:0]             coarse_atten,
  output logic      [2:0]             fine_atten_db,
  output logic      [7:0]             first_symbol_high_len,
  output logic      [15:0]            first_symbol_cycles,
  output logic      [2:0]             comparison_freq_sel,
  output logic      [7:0]             comparison_freq_khz,
  output logic      [9:0]             main_div_b,
  output logic      [9:0]             main_div_a,
  output logic      [9:0]             aux_div_b,
  output logic      [9:0]             aux_div_a,
  output logic      [15:0]            main_ratio,
  output logic      [15:0]            aux_ratio,
  output logic      [25:0]            carrier_khz,
  output logic                        config_fault
);

  // -------------------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------------------
  logic [7:0] regs [mod_pll_pkg::reg_count];

  localparam logic [7:0] rst_vals [mod_pll_pkg::reg_count] = '{
    mod_pll_pkg::rst_ramp_level, mod_pll_pkg::rst_first_tari,
    mod_pll_pkg::rst_main_one,   mod_pll_pkg::rst_main_two,
    mod_pll_pkg::rst_main_three, mod_pll_pkg::rst_aux_one,
    mod_pll_pkg::rst_aux_two,    mod_pll_pkg::rst_aux_three, 8'h00};

  localparam logic [7:0] wr_masks [mod_pll_pkg::reg_count] = '{
    mod_pll_pkg::mask_full,  mod_pll_pkg::mask_full,
    mod_pll_pkg::mask_ref_b, mod_pll_pkg::mask_full,
    mod_pll_pkg::mask_full,  mod_pll_pkg::mask_b_high,
    mod_pll_pkg::mask_full,  mod_pll_pkg::mask_full, 8'h00};

  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------
  function automatic logic [3:0] reg_slot(input logic [7:0] addr);
    logic [5:0] w;
    w = addr[7:mod_pll_pkg::addr_lsb];
    if (w >= mod_pll_pkg::idx_ramp_level[5:0] && w <= mod_pll_pkg::idx_status[5:0])
      reg_slot = 4'(w - mod_pll_pkg::idx_ramp_level[5:0]);
    else
      reg_slot = 4'hf;
  endfunction : reg_slot

  wire [3:0] slot      = reg_slot(paddr);
  wire       mapped    = (slot != 4'hf) && (paddr[1:0] == 2'h0);
  wire       access    = psel && penable && !pready;
  wire       wr_ok     = access && pwrite && mapped && pstrb[0]
                         && (slot != 4'(mod_pll_pkg::reg_count - 1));
  wire       bad       = !mapped || (pwrite && slot == 4'(mod_pll_pkg::reg_count - 1));

  // -------------------------------------------------------------------------
  // field views
  // -------------------------------------------------------------------------
  wire [7:0] r_lvl  = regs[0];
  wire [7:0] r_tari = regs[1];
  wire [7:0] r_m1   = regs[2];
  wire [7:0] r_m2   = regs[3];
  wire [7:0] r_m3   = regs[4];
  wire [7:0] r_x1   = regs[5];
  wire [7:0] r_x2   = regs[6];
  wire [7:0] r_x3   = regs[7];

  wire [1:0] f_ramp   = r_lvl[mod_pll_pkg::ramp_hi:mod_pll_pkg::ramp_lo];
  wire [1:0] f_coarse = r_lvl[mod_pll_pkg::coarse_hi:mod_pll_pkg::coarse_lo];
  wire [2:0] f_fine   = r_lvl[mod_pll_pkg::fine_hi:0];
  wire [2:0] f_ref    = r_m1[mod_pll_pkg::ref_hi:mod_pll_pkg::ref_lo];
  wire [9:0] f_mb     = {r_m1[mod_pll_pkg::b_high_hi:0], r_m2[7:mod_pll_pkg::b_low_lo]};
  wire [9:0] f_ma     = {r_m2[mod_pll_pkg::a_high_hi:0], r_m3};
  wire [9:0] f_xb     = {r_x1[mod_pll_pkg::b_high_hi:0], r_x2[7:mod_pll_pkg::b_low_lo]};
  wire [9:0] f_xa     = {r_x2[mod_pll_pkg::a_high_hi:0], r_x3};

  // ramp length in clock cycles, zero when Tari sets it
  logic [17:0] next_ramp_cycles;
  always_comb
  begin
    unique case (f_ramp)
      mod_pll_pkg::ramp_tari:  next_ramp_cycles = 18'h00000;
      mod_pll_pkg::ramp_100us: next_ramp_cycles = 18'(mod_pll_pkg::ramp_100_cyc);
      mod_pll_pkg::ramp_200us: next_ramp_cycles = 18'(mod_pll_pkg::ramp_200_cyc);
      mod_pll_pkg::ramp_400us: next_ramp_cycles = 18'(mod_pll_pkg::ramp_400_cyc);
    endcase
  end

  // reserved selector codes give zero, so the carrier estimate reads zero
  logic [7:0] next_freq;
  logic       ref_bad;
  always_comb
  begin
    ref_bad = 1'b0;
    unique case (f_ref)
      mod_pll_pkg::ref_125k: next_freq = mod_pll_pkg::freq_125_khz;
      mod_pll_pkg::ref_100k: next_freq = mod_pll_pkg::freq_100_khz;
      mod_pll_pkg::ref_50k:  next_freq = mod_pll_pkg::freq_50_khz;
      mod_pll_pkg::ref_25k:  next_freq = mod_pll_pkg::freq_25_khz;
      default:
      begin
        next_freq = 8'h00;
        ref_bad   = 1'b1;
      end
    endcase
  end

  // software is trusted with codes; the fault flag only reports them
  wire coarse_bad = (f_coarse == mod_pll_pkg::coarse_rsvd);
  wire tari_bad   = (r_tari < mod_pll_pkg::tari_len_min) ||
                    (r_tari > mod_pll_pkg::tari_len_max);
  wire next_fault = coarse_bad || tari_bad || ref_bad;

  // -------------------------------------------------------------------------
  // ratio and timing helpers
  // -------------------------------------------------------------------------
  logic [15:0] main_n;
  logic [15:0] aux_n;

  synth_ratio #(.div_w(mod_pll_pkg::div_w)) u_main_ratio (
    .pclk    (pclk),
    .presetn (presetn),
    .div_b   (f_mb),
    .div_a   (f_ma),
    .ratio   (main_n)
  );

  synth_ratio #(.div_w(mod_pll_pkg::div_w)) u_aux_ratio (
    .pclk    (pclk),
    .presetn (presetn),
    .div_b   (f_xb),
    .div_a   (f_xa),
    .ratio   (aux_n)
  );

  first_tari_step u_tari (
    .pclk        (pclk),
    .presetn     (presetn),
    .len_code    (r_tari),
    .tari_sel    (tari_sel),
    .high_cycles (first_symbol_cycles)
  );

  assign main_ratio = main_n;
  assign aux_ratio  = aux_n;

  wire [25:0] next_carrier = 26'(main_n) * 26'(comparison_freq_khz);

  // -------------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < mod_pll_pkg::reg_count; g++)
    begin : g_reg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          regs[g] <= rst_vals[g];
        else if (wr_ok && slot == 4'(g))
          regs[g] <= pwdata[7:0] & wr_masks[g];
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // bus answer: one wait state, pready on the second access cycle
  // -------------------------------------------------------------------------
  wire [7:0] status_byte = {7'h00, config_fault};
  // unmapped reads return zero, status included at a misaligned address
  wire [7:0] rd_byte     = !mapped ? 8'h00 :
                           (slot == 4'(mod_pll_pkg::reg_count - 1)) ? status_byte : regs[slot];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= access && bad;
      prdata  <= (access && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // -------------------------------------------------------------------------
  // registered field outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_code             <= 2'h0;
      ramp_cycles           <= 18'h00000;
      ramp_follows_tari     <= 1'b1;
      sine_transient        <= 1'b0;
      coarse_atten          <= 2'h0;
      fine_atten_db         <= 3'h0;
      first_symbol_high_len <= 8'h00;
      comparison_freq_sel   <= 3'h0;
      comparison_freq_khz   <= 8'h00;
      main_div_b            <= 10'h000;
      main_div_a            <= 10'h000;
      aux_div_b             <= 10'h000;
      aux_div_a             <= 10'h000;
      carrier_khz           <= 26'h0000000;
      config_fault          <= 1'b0;
    end
    else
    begin
      ramp_code             <= f_ramp;
      ramp_cycles           <= next_ramp_cycles;
      ramp_follows_tari     <= (f_ramp == mod_pll_pkg::ramp_tari);
      sine_transient        <= r_lvl[mod_pll_pkg::shape_bit];
      coarse_atten          <= f_coarse;
      fine_atten_db         <= f_fine;
      first_symbol_high_len <= r_tari;
      comparison_freq_sel   <= f_ref;
      comparison_freq_khz   <= next_freq;
      main_div_b            <= f_mb;
      main_div_a            <= f_ma;
      aux_div_b             <= f_xb;
      aux_div_a             <= f_xa;
      carrier_khz           <= next_carrier;
      config_fault          <= next_fault;
    end
  end

endmodule : modulator_pll_config_regs

/* verif/modulator_pll_config_regs_asserts.sv */
module modulator_pll_config_regs_asserts (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire mod_pll_pkg::tari_sel_t tari_sel,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [1:0]             ramp_code,
  input wire logic [17:0]            ramp_cycles,
  input wire logic                   ramp_follows_tari,
  input wire logic [1:0]             coarse_atten,
  input wire logic [7:0]             first_symbol_high_len,
  input wire logic [15:0]            first_symbol_cycles,
  input wire logic [2:0]             comparison_freq_sel,
  input wire logic [7:0]             comparison_freq_khz,
  input wire logic [9:0]             main_div_b,
  input wire logic [9:0]             main_div_a,
  input wire logic [9:0]             aux_div_b,
  input wire logic [9:0]             aux_div_a,
  input wire logic [15:0]            main_ratio,
  input wire logic [15:0]            aux_ratio,
  input wire logic [25:0]            carrier_khz,
  input wire logic                   config_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // expected values
  // ---------------------------------------------------------------
  wire logic [5:0]  step_cyc;
  wire logic [7:0]  khz_exp;
  wire logic [17:0] ramp_exp;
  wire logic        fault_exp;
  assign step_cyc = (tari_sel == mod_pll_pkg::tari_short) ? 6'h0d :
                    (tari_sel == mod_pll_pkg::tari_mid) ? 6'h19 : 6'h32;
  assign khz_exp = (comparison_freq_sel == 3'h4) ? 8'h7d :
                   (comparison_freq_sel == 3'h5) ? 8'h64 :
                   (comparison_freq_sel == 3'h6) ? 8'h32 :
                   (comparison_freq_sel == 3'h7) ? 8'h19 : 8'h00;
  assign ramp_exp = (ramp_code == 2'h1) ? 18'h061a8 : (ramp_code == 2'h2) ? 18'h0c350 :
                    (ramp_code == 2'h3) ? 18'h186a0 : 18'h00000;
  assign fault_exp = (coarse_atten == 2'h3) || (first_symbol_high_len < 8'h5f) ||
                     (first_symbol_high_len > 8'h9d) || !comparison_freq_sel[2];

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  chk_ready_wait: assert property (s_access |=> s_answer)
    else $error("pready not a single pulse after one wait state");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answered access");
  chk_read_zero: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata nonzero outside read answer");
  chk_ramp_time: assert property ($stable(ramp_code) |-> ramp_cycles == ramp_exp)
    else $error("ramp cycles do not match ramp code");
  chk_ramp_tari: assert property (
    $stable(ramp_code) |-> ramp_follows_tari == (ramp_code == 2'h0))
    else $error("ramp tari flag wrong");
  chk_tari_cycles: assert property (
    (first_symbol_high_len == $past(first_symbol_high_len, 2)) && (tari_sel == $past(tari_sel, 2))
    |-> first_symbol_cycles == first_symbol_high_len * step_cyc)
    else $error("first symbol cycles wrong");
  chk_freq_map: assert property (
    $stable(comparison_freq_sel) |-> comparison_freq_khz == khz_exp)
    else $error("comparison frequency wrong");
  chk_main_ratio: assert property (
    (main_div_b == $past(main_div_b, 2)) && (main_div_a == $past(main_div_a, 2))
    |-> main_ratio == 16'h20 * main_div_b + 16'h21 * main_div_a)
    else $error("main ratio wrong");
  chk_aux_ratio: assert property (
    (aux_div_b == $past(aux_div_b, 2)) && (aux_div_a == $past(aux_div_a, 2))
    |-> aux_ratio == 16'h20 * aux_div_b + 16'h21 * aux_div_a)
    else $error("aux ratio wrong");
  chk_carrier_freq: assert property ($stable(main_ratio) && $stable(comparison_freq_khz)
    |-> carrier_khz == main_ratio * comparison_freq_khz)
    else $error("carrier frequency wrong");
  // fault flag and its inputs read zero in reset, so the first edge after release is skipped
  chk_fault_flag: assert property ($past(presetn) && $stable(coarse_atten)
    && $stable(first_symbol_high_len) && $stable(comparison_freq_sel)
    |-> config_fault == fault_exp)
    else $error("config fault flag wrong");
endmodule : modulator_pll_config_regs_asserts

bind modulator_pll_config_regs modulator_pll_config_regs_asserts u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .tari_sel, .prdata, .pready, .pslverr,
  .ramp_code, .ramp_cycles, .ramp_follows_tari, .coarse_atten, .first_symbol_high_len,
  .first_symbol_cycles, .comparison_freq_sel, .comparison_freq_khz, .main_div_b, .main_div_a,
  .aux_div_b, .aux_div_a, .main_ratio, .aux_ratio, .carrier_khz, .config_fault
);

/* verif/tb_modulator_pll_config_regs.sv */
module tb_modulator_pll_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [3:0]             pstrb = 4'h0;
  mod_pll_pkg::tari_sel_t tari_sel = mod_pll_pkg::tari_mid;
  logic [31:0]            prdata, rdata;
  logic                   pready, pslverr, rerr, ramp_follows_tari, sine_transient, config_fault;
  logic [1:0]             ramp_code, coarse_atten;
  logic [17:0]            ramp_cycles;
  logic [2:0]             fine_atten_db, comparison_freq_sel;
  logic [7:0]             first_symbol_high_len, comparison_freq_khz, v;
  logic [15:0]            first_symbol_cycles, main_ratio, aux_ratio;
  logic [9:0]             main_div_b, main_div_a, aux_div_b, aux_div_a;
  logic [25:0]            carrier_khz;
  int                     fails = 0;
  int                     n_compared = 0;
  logic [7:0]  rst_tab [8] = '{8'h00, 8'h7e, 8'h64, 8'h68, 8'hfc, 8'h04, 8'h61, 8'h18};
  logic [31:0] ramp_tab [4] = '{32'h0, 32'h61a8, 32'hc350, 32'h186a0};
  logic [7:0]  len_tab [4] = '{8'h5f, 8'h9d, 8'h5e, 8'h9e};
  logic [31:0] step_tab [3] = '{32'hd, 32'h19, 32'h32};
  logic [31:0] khz_tab [5] = '{32'h0, 32'h7d, 32'h64, 32'h32, 32'h19};

  modulator_pll_config_regs u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .tari_sel, .prdata,
    .pready, .pslverr, .ramp_code, .ramp_cycles, .ramp_follows_tari, .sine_transient,
    .coarse_atten, .fine_atten_db, .first_symbol_high_len, .first_symbol_cycles,
    .comparison_freq_sel, .comparison_freq_khz, .main_div_b, .main_div_a, .aux_div_b,
    .aux_div_a, .main_ratio, .aux_ratio, .carrier_khz, .config_fault
  );

  always #2 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : ba

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: the watchdog ends a hung access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic err);
    apb(1'b1, a, d, s);
    cmp({31'h0, rerr}, {31'h0, err});
  endtask : wr_chk

  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, 4'h0);
    cmp(rdata, e);
    cmp({31'h0, rerr}, {31'h0, err});
  endtask : rd_chk

  // derived outputs lag a write by up to two edges
  task settle;
    repeat (4) @(posedge pclk);
  endtask : settle

  task print_verdict;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    #200000;
    fails++;
    print_verdict;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk(ba(8'(8'h15 + i)), 32'(rst_tab[i]), 1'b0);
    cmp(32'(main_ratio), 32'h43bc);
    cmp(32'(carrier_khz), 32'hd3ab8);
    cmp(32'(first_symbol_cycles), 32'hc4e);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      v = {2'(i), i[0], 2'(i), 3'(2 * i + 1)};
      wr_chk(ba(8'h15), 32'(v), 4'hf, 1'b0);
      settle;
      cmp(32'(ramp_cycles), ramp_tab[i]);
      cmp(32'(ramp_code), 32'(i));
      cmp(32'(ramp_follows_tari), 32'(i == 0));
      cmp(32'(sine_transient), 32'(i % 2));
      cmp(32'(coarse_atten), 32'(i));
      cmp(32'(fine_atten_db), 32'(2 * i + 1));
      cmp(32'(config_fault), 32'(i == 3));
      rd_chk(8'h74, 32'(i == 3), 1'b0);
      rd_chk(8'h75, 32'h0, 1'b1);
      rd_chk(ba(8'h15), 32'(v), 1'b0);
    end
    wr_chk(ba(8'h15), 32'h0, 4'hf, 1'b0);
    $display("test modulator fields done");
    for (int j = 0; j < 4; j++)
    begin
      wr_chk(ba(8'h16), 32'(len_tab[j]), 4'hf, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
        @(posedge pclk);
        tari_sel <= mod_pll_pkg::tari_sel_t'(k);
        settle;
        cmp(32'(first_symbol_cycles), 32'(len_tab[j]) * step_tab[k]);
      end
      cmp(32'(config_fault), 32'(j > 1));
      cmp(32'(first_symbol_high_len), 32'(len_tab[j]));
    end
    wr_chk(ba(8'h16), 32'h7e, 4'hf, 1'b0);
    $display("test first tari done");
    for (int c = 3; c < 8; c++)
    begin
      wr_chk(ba(8'h17), 32'({1'b1, 3'(c), 4'h4}), 4'hf, 1'b0);
      settle;
      rd_chk(ba(8'h17), 32'({4'(c), 4'h4}), 1'b0);
      cmp(32'(comparison_freq_sel), 32'(c));
      cmp(32'(comparison_freq_khz), khz_tab[c - 3]);
      cmp(32'(config_fault), 32'(c == 3));
    end
    $display("test reference select done");
    wr_chk(ba(8'h17), 32'h66, 4'hf, 1'b0);
    wr_chk(ba(8'h18), 32'h51, 4'hf, 1'b0);
    wr_chk(ba(8'h19), 32'h86, 4'hf, 1'b0);
    wr_chk(ba(8'h1a), 32'hfb, 4'hf, 1'b0);
    wr_chk(ba(8'h1b), 32'h5d, 4'hf, 1'b0);
    wr_chk(ba(8'h1c), 32'h9b, 4'hf, 1'b0);
    settle;
    cmp(32'(main_div_b), 32'h194);
    cmp(32'(main_div_a), 32'h186);
    cmp(32'(main_ratio), 32'h64c6);
    cmp(32'(carrier_khz), 32'h13aeac);
    rd_chk(ba(8'h1a), 32'h0b, 1'b0);
    cmp(32'(aux_div_b), 32'h2d7);
    cmp(32'(aux_div_a), 32'h19b);
    cmp(32'(aux_ratio), 32'h8fdb);
    $display("test dividers done");
    rd_chk(8'h80, 32'h0, 1'b1);
    rd_chk(8'h55, 32'h0, 1'b1);
    wr_chk(8'h74, 32'h1, 4'hf, 1'b1);
    wr_chk(ba(8'h19), 32'h11, 4'he, 1'b0);
    rd_chk(ba(8'h19), 32'h86, 1'b0);
    rd_chk(8'h74, 32'h0, 1'b0);
    $display("test refusals done");
    print_verdict;
  end
endmodule : tb_modulator_pll_config_regs
